/* shared/dcp_pkg.sv */
// Package for the clock-enable power-state block of a DDR3 device.
// Assumes one 40 MHz core clock; used by the power controller and the bench, not by the synchroniser.
package dcp_pkg;
  // Core clock period and derived counts
  localparam int CLK_PERIOD_NS = 25;
  // Bus burst in clock edges before a running read or write ends
  localparam int BURST_EDGES = 4;
  // Precharge completion in edges
  localparam int PRE_EDGES = 3;
  // Refresh busy time (tRFC) in ns, counted as a least time
  localparam int REFRESH_NS = 110;
  localparam int REFRESH_CYC = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam int BANKS = 8;
  // Command encoding: {ras_n, cas_n, we_n} with cs_n low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_ZQ = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // Power states
  typedef enum logic [2:0] {
    DCP_IDLE, DCP_ACTIVE, DCP_BUSY, DCP_REFRESHING,
    DCP_ACT_PD, DCP_PRE_PD, DCP_SELF_REF
  } dcp_state_e;
endpackage : dcp_pkg

/* hw/dcp_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes a single clock and an async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module dcp_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input and filtered level
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  logic next_dout;

  // Output changes only when stages two and three agree
  always_comb begin
    next_dout = dout;
    if (s2 == s3) begin
      next_dout = s3;
    end
  end

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : dcp_sync
`default_nettype wire

/* hw/dcp_power_ctrl.sv */
// Clock-enable power-state logic of a DDR3 device: power-down, self
// refresh entry and exit, command gating around CKE transitions.
// Assumes CKE and command pins sampled on the rising edge of ref_clk,
// and a controller that keeps the timing it is responsible for.
`timescale 1ns/100ps
`default_nettype none
module dcp_power_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic addr_ap,
  input wire logic [2:0] bank,
  input wire logic odt,
  // Status
  output dcp_pkg::dcp_state_e power_state,
  output logic cmd_accept,
  output logic cmd_illegal,
  output logic odt_enable,
  output logic self_ref_exit_async,
  output logic internal_refresh
);
  import dcp_pkg::*;

  logic rst_sync1;
  logic rst_sync2;
  logic cke_prev;
  logic odt_level;
  logic [BANKS-1:0] open_banks;
  logic [CNT_W-1:0] busy_cnt;
  logic pd_pending;
  dcp_state_e state;
  dcp_state_e next_state;
  logic [BANKS-1:0] next_open_banks;
  logic [CNT_W-1:0] next_busy_cnt;
  logic next_pd_pending;
  logic next_accept;
  logic next_illegal;
  logic [2:0] cmd;
  logic is_nop;

  function automatic logic [CNT_W-1:0] cnt_of(input int n);
    cnt_of = CNT_W'(n);
  endfunction : cnt_of

  // Reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
    end
  end

  // Self-refresh exit shown straight from the pin, so a stopped clock
  // still sees it; drops as the clocked state leaves self refresh
  assign self_ref_exit_async = cke && (state == DCP_SELF_REF);

  // ODT level filtered; it only gates termination, never the state
  dcp_sync odt_sync_u (
    // Clock and reset
    .clk(ref_clk),
    .rst_n(rst_sync2),
    // Pin level in, filtered level out
    .din(odt),
    .dout(odt_level)
  );

  // Decode; deselect behaves as NOP
  assign cmd = cs_n ? CMD_NOP : {ras_n, cas_n, we_n};
  assign is_nop = (cmd == CMD_NOP);

  // Next power state from CKE pair and command; ODT never read here
  always_comb begin
    next_state = state;
    next_open_banks = open_banks;
    next_busy_cnt = busy_cnt;
    next_pd_pending = pd_pending;
    next_accept = 1'b0;
    next_illegal = 1'b0;
    if (busy_cnt != '0) begin
      next_busy_cnt = busy_cnt - cnt_of(1);
    end
    unique case ({cke_prev, cke})
      2'b00: begin
        // Low-low keeps power state, pins ignored; only the deferred entry below can move it
        next_state = state;
      end
      2'b01: begin
        if (state == DCP_ACT_PD || state == DCP_PRE_PD ||
            state == DCP_SELF_REF) begin
          next_illegal = !is_nop;
          next_state = (open_banks != '0) ? DCP_ACTIVE : DCP_IDLE;
        end
      end
      2'b10: begin
        if (cmd == CMD_REF && state == DCP_IDLE) begin
          next_state = DCP_SELF_REF;
        end else if (!is_nop) begin
          next_illegal = 1'b1;
        end else if (state == DCP_BUSY && busy_cnt > cnt_of(1)) begin
          // Decide bank state when the operation completes
          next_pd_pending = 1'b1;
          next_state = DCP_BUSY;
        end else if (state == DCP_ACTIVE ||
                     (state == DCP_BUSY && open_banks != '0)) begin
          next_state = DCP_ACT_PD;
        end else begin
          next_state = DCP_PRE_PD;
        end
      end
      2'b11: begin
        next_accept = 1'b1;
        if (cmd == CMD_ACT) begin
          next_open_banks[bank] = 1'b1;
        end else if (cmd == CMD_PRE) begin
          if (addr_ap) begin
            next_open_banks = '0;
          end else begin
            next_open_banks[bank] = 1'b0;
          end
        end
        if (cmd == CMD_RD || cmd == CMD_WR) begin
          next_busy_cnt = cnt_of(BURST_EDGES);
          next_state = DCP_BUSY;
          if (addr_ap) begin
            next_open_banks[bank] = 1'b0;
          end
        end else if (cmd == CMD_PRE) begin
          next_busy_cnt = cnt_of(PRE_EDGES);
          next_state = DCP_BUSY;
        end else if (cmd == CMD_REF) begin
          next_busy_cnt = cnt_of(REFRESH_CYC);
          next_state = DCP_REFRESHING;
        end else if (busy_cnt <= cnt_of(1)) begin
          next_state = (next_open_banks != '0) ? DCP_ACTIVE : DCP_IDLE;
        end
      end
      default: next_state = state;
    endcase
    // Deferred power-down entry once the operation ends
    if (pd_pending && busy_cnt <= cnt_of(1) && state == DCP_BUSY) begin
      next_pd_pending = 1'b0;
      next_state = (open_banks != '0) ? DCP_ACT_PD : DCP_PRE_PD;
    end
  end

  // Registered state, all on the rising edge
  always_ff @(posedge ref_clk or negedge rst_sync2) begin
    if (!rst_sync2) begin
      state <= DCP_IDLE;
      cke_prev <= 1'b0;
      open_banks <= '0;
      busy_cnt <= '0;
      pd_pending <= 1'b0;
      cmd_accept <= 1'b0;
      cmd_illegal <= 1'b0;
    end else begin
      state <= next_state;
      cke_prev <= cke;
      open_banks <= next_open_banks;
      busy_cnt <= next_busy_cnt;
      pd_pending <= next_pd_pending;
      cmd_accept <= next_accept;
      cmd_illegal <= next_illegal;
    end
  end

  assign power_state = state;
  // Termination withheld in self refresh
  assign odt_enable = odt_level && (state != DCP_SELF_REF);
  // Refresh engine only runs in the refreshing state, never in power-down
  assign internal_refresh = (state == DCP_REFRESHING);

  // Checks; a deferred entry is the one legal move while CKE stays low
  sr_entry_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync2)
    (state == DCP_IDLE && cke_prev && !cke && !cs_n &&
     {ras_n, cas_n, we_n} == CMD_REF) |=> state == DCP_SELF_REF)
    else $error("self refresh not entered");
  sr_source_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync2)
    $rose(state == DCP_SELF_REF) |-> $past(state) == DCP_IDLE)
    else $error("self refresh from non-idle");
  pd_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync2)
    (!cke_prev && !cke && !pd_pending) |=> state == $past(state))
    else $error("state moved with cke low");
  pd_defer_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync2)
    (pd_pending && state == DCP_BUSY && busy_cnt == cnt_of(1)) |=>
    (state == DCP_ACT_PD || state == DCP_PRE_PD))
    else $error("deferred power-down missed");
  pd_exit_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync2)
    (!cke_prev && cke && state == DCP_PRE_PD) |=> state == DCP_IDLE)
    else $error("power-down exit missed");
  pd_illegal_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync2)
    (cke_prev && !cke && !is_nop &&
     !(state == DCP_IDLE && cmd == CMD_REF)) |=> cmd_illegal)
    else $error("bad command on entry not flagged");
  odt_sr_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync2)
    state == DCP_SELF_REF |-> !odt_enable)
    else $error("odt on in self refresh");
  pd_norefresh_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync2)
    (state == DCP_ACT_PD || state == DCP_PRE_PD) |-> !internal_refresh)
    else $error("refresh in power-down");
  act_pd_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync2)
    (cke_prev && !cke && is_nop && state == DCP_ACTIVE)
    |=> state == DCP_ACT_PD)
    else $error("active power-down missed");
  sr_exit_a: assert property (
    @(posedge ref_clk) disable iff (!rst_sync2)
    (state == DCP_SELF_REF && !cke_prev && cke) |=>
    (state == DCP_IDLE && !cmd_accept))
    else $error("self refresh exit wrong");
endmodule : dcp_power_ctrl
`default_nettype wire

/* verification/dcp_ctrl_model.sv */
// Controller-side model driving clock enable and command pins.
// Assumes the device samples every pin on the rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none
module dcp_ctrl_model #(
  parameter int CKE_HOLD = 3,
  parameter int XS_EDGES = 6
) (
  // Clock
  input wire logic ref_clk,
  // Pins toward the device
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd,
  output logic addr_ap,
  output logic [2:0] bank
);
  import dcp_pkg::*;
  int held = CKE_HOLD;
  int xs = 0;
  bit in_sr = 0;
  // Idle pins; no mode-register command is ever sent, so CKE never
  // drops inside tMRD or tMOD
  initial begin
    cke = 1'h1;
    cs_n = 1'h1;
    cmd = CMD_NOP;
    addr_ap = 1'h0;
    bank = 3'h0;
  end
  // One command edge, then deselect; raw skips only the NOP substitution on a CKE change
  task issue(input logic c, input logic [2:0] k, input logic ap,
             input logic [2:0] bk, input bit raw);
    logic [2:0] op;
    op = k;
    // A new CKE level is held for its minimum time
    while (c !== cke && held < CKE_HOLD) begin
      @(posedge ref_clk);
      held++;
    end
    // Quiet edges after self-refresh exit; no read, write or ODT in them
    repeat (xs) @(posedge ref_clk);
    xs = 0;
    // Power-down edges carry NOP; self-refresh entry keeps its REFRESH
    if (c !== cke && !raw && !(c === 1'h0 && k === CMD_REF)) begin
      op = CMD_NOP;
    end
    // Power state tracked as commands go out
    if (c === 1'h0 && cke === 1'h1 && k === CMD_REF) in_sr = 1;
    held = (c !== cke) ? 0 : held + 2;
    @(posedge ref_clk);
    cke <= c;
    cs_n <= 1'h0;
    cmd <= op;
    addr_ap <= ap;
    bank <= bk;
    @(posedge ref_clk);
    cs_n <= 1'h1; // Deselect, same effect as NOP
  endtask : issue
  // Raise CKE alone to leave self refresh, then stay quiet for tXS
  task leave_sr();
    // Self refresh too keeps CKE low for its minimum time
    while (held < CKE_HOLD) begin
      @(posedge ref_clk);
      held++;
    end
    @(posedge ref_clk);
    cke <= 1'h1;
    cs_n <= 1'h1;
    if (in_sr) xs = XS_EDGES;
    in_sr = 0;
    held = 0;
  endtask : leave_sr
endmodule : dcp_ctrl_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the clock-enable power-state block.
// Assumes the controller model file and the design package are compiled.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dcp_pkg::*;
  logic ref_clk, resetn, odt, cke, cs_n, addr_ap;
  logic [2:0] cmd, bank;
  dcp_state_e power_state;
  logic cmd_accept, cmd_illegal, odt_enable, srx, irf;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  dcp_power_ctrl dut_u (.ref_clk(ref_clk), .resetn(resetn), .cke(cke),
    .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
    .addr_ap(addr_ap), .bank(bank), .odt(odt), .power_state(power_state),
    .cmd_accept(cmd_accept), .cmd_illegal(cmd_illegal),
    .odt_enable(odt_enable), .self_ref_exit_async(srx),
    .internal_refresh(irf));
  dcp_ctrl_model ctl_u (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n),
    .cmd(cmd), .addr_ap(addr_ap), .bank(bank));
  // Clock at 40 MHz
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // Hang guard, well above the roughly 75 edges the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      wrap_up();
    end
  end
  task chk(input string n, input logic [2:0] s, input logic [2:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  // Bounded wait, since completion of a burst sets the moment
  task wait_st(input dcp_state_e e, input int n);
    int i;
    i = 0;
    #1;
    while (power_state !== e && i < n) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    chk("power_state", power_state, e);
  endtask : wait_st
  task t_idle_pd();
    ctl_u.issue(1'h1, CMD_NOP, 1'h0, 3'h0, 0);
    #1 chk("accept", {2'h0, cmd_accept}, 3'h1);
    ctl_u.issue(1'h0, CMD_NOP, 1'h0, 3'h0, 0);
    #1 chk("state", power_state, DCP_PRE_PD);
    chk("accept", {2'h0, cmd_accept}, 3'h0);
    ctl_u.issue(1'h0, CMD_REF, 1'h1, 3'h5, 1);
    #1 chk("state", power_state, DCP_PRE_PD);
    chk("illegal", {2'h0, cmd_illegal}, 3'h0);
    chk("refresh", {2'h0, irf}, 3'h0);
    ctl_u.issue(1'h1, CMD_NOP, 1'h0, 3'h0, 0);
    #1 chk("state", power_state, DCP_IDLE);
    $display("idle power-down done");
  endtask : t_idle_pd
  task t_active_pd();
    ctl_u.issue(1'h1, CMD_ACT, 1'h0, 3'h1, 0);
    #1 chk("state", power_state, DCP_ACTIVE);
    ctl_u.issue(1'h1, CMD_WR, 1'h0, 3'h1, 0);
    ctl_u.issue(1'h0, CMD_NOP, 1'h0, 3'h0, 0);
    wait_st(DCP_ACT_PD, 8);
    ctl_u.issue(1'h1, CMD_NOP, 1'h0, 3'h0, 0);
    #1 chk("state", power_state, DCP_ACTIVE);
    ctl_u.issue(1'h0, CMD_NOP, 1'h0, 3'h0, 0);
    #1 chk("state", power_state, DCP_ACT_PD);
    ctl_u.issue(1'h1, CMD_NOP, 1'h0, 3'h0, 0);
    #1 chk("state", power_state, DCP_ACTIVE);
    ctl_u.issue(1'h1, CMD_PRE, 1'h0, 3'h1, 0);
    ctl_u.issue(1'h0, CMD_NOP, 1'h0, 3'h0, 0);
    wait_st(DCP_PRE_PD, 8);
    ctl_u.issue(1'h1, CMD_NOP, 1'h0, 3'h0, 0);
    wait_st(DCP_IDLE, 2);
    $display("active power-down done");
  endtask : t_active_pd
  task t_self_ref();
    wait_st(DCP_IDLE, 8);
    @(posedge ref_clk);
    odt <= 1'h1;
    ctl_u.issue(1'h0, CMD_REF, 1'h0, 3'h0, 0);
    #1 chk("state", power_state, DCP_SELF_REF);
    chk("odt_en", {2'h0, odt_enable}, 3'h0);
    ctl_u.issue(1'h0, CMD_ACT, 1'h1, 3'h6, 1);
    #1 chk("state", power_state, DCP_SELF_REF);
    ctl_u.leave_sr();
    #1 chk("srx", {2'h0, srx}, 3'h1);
    @(posedge ref_clk);
    #1 chk("state", power_state, DCP_IDLE);
    chk("srx", {2'h0, srx}, 3'h0);
    chk("odt_en", {2'h0, odt_enable}, 3'h1);
    @(posedge ref_clk);
    odt <= 1'h0;
    $display("self refresh done");
  endtask : t_self_ref
  task t_bad_entry();
    ctl_u.issue(1'h0, CMD_ACT, 1'h0, 3'h2, 1);
    #1 chk("illegal", {2'h0, cmd_illegal}, 3'h1);
    $display("illegal entry done");
  endtask : t_bad_entry
  // Reset for five cycles, then the tests in turn
  initial begin
    resetn = 1'h0;
    odt = 1'h0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'h1;
    repeat (4) @(posedge ref_clk);
    t_idle_pd();
    t_active_pd();
    t_self_ref();
    t_bad_entry();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
